// ==== design/lls_pkg.sv ====
// Shared constants, config carriers and helpers for the LVDS lane block.
// Assumes one system clock acting as the serial bit clock; word rates are
// produced inside the block as one-cycle enable pulses.
package lls_pkg;

   // Word widths
   localparam logic [3:0] LLS_W_BYPASS = 4'h1;
   localparam logic [3:0] LLS_W_MAX    = 4'h8;

   // Static input delay step and its range
   localparam int unsigned LLS_DLY_STEP_PS = 25;
   localparam logic [5:0]  LLS_DLY_MAX     = 6'h3f;

   // Reset values
   localparam logic [7:0] LLS_WORD_RST = 8'h00;
   localparam logic       LLS_PAD_RST  = 1'b0;
   localparam logic [3:0] LLS_CNT_RST  = 4'h0;

   typedef logic [7:0] lls_word_t;

   typedef struct packed {
      logic       ref_clk_mode;   // 1: forwarded reference clock
      logic       ser_en;         // 0: plain output buffer
      logic [3:0] width;          // Serialization factor
      logic       clk_div2;       // Clock output at half word rate
   } lls_tx_cfg_s;

   typedef struct packed {
      logic       ser_en;         // 0: plain input buffer
      logic [3:0] width;          // Deserialization factor
      logic       alt_conn;       // Alternate PLL reference connection
      logic [5:0] delay;          // Static delay taps
   } lls_rx_cfg_s;

   // Working width: bypass or a width of 0 collapses to one, widths above eight clamp to eight
   function automatic logic [3:0] lls_eff_width(input logic en, input logic [3:0] w);
      logic [3:0] r;
      r = w;
      if (!en || w <= LLS_W_BYPASS)
         r = LLS_W_BYPASS;
      else if (w > LLS_W_MAX)
         r = LLS_W_MAX;
      return r;
   endfunction

   // Low bits kept for a given word width
   function automatic lls_word_t lls_width_mask(input logic [3:0] w);
      lls_word_t m;
      m = 8'hff >> (4'(LLS_W_MAX - w));
      return m;
   endfunction

endpackage

// ==== design/lls_tx_ser.sv ====
// Transmit shifter: loads a word on the word strobe, then shifts MSB first.
// Assumes width_i already legal (1..8) and stable between strobes.
`timescale 1ns/100ps
module lls_tx_ser
   import lls_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       word_stb_i,
   input  wire logic [3:0] width_i,
   input  wire lls_word_t  word_i,
   output logic            ser_bit_o
);

   lls_word_t sh_q;

   ////////////////////////////////////////////////////////////////////////
   // Capture left-justified so the top bit always leaves first
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sh_q <= LLS_WORD_RST;
      else if (word_stb_i)
         sh_q <= lls_word_t'(word_i << (4'(LLS_W_MAX - width_i)));
      else
         sh_q <= {sh_q[6:0], 1'b0};
   end

   assign ser_bit_o = sh_q[7];

   // Eight shifts past a load leave nothing, even for a full-width word
   shift_fill_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      word_stb_i ##1 !word_stb_i [*8] |=> sh_q == LLS_WORD_RST)
      else $error("tx shifter not drained");

endmodule

// ==== design/lls_rx_des.sv ====
// Receive shifter: collects bits and hands a masked word out on the strobe.
// Assumes bit_i is already synchronous to clk_sys_i.
`timescale 1ns/100ps
module lls_rx_des
   import lls_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       word_stb_i,
   input  wire logic [3:0] width_i,
   input  wire logic       bit_i,
   output lls_word_t       word_o
);

   lls_word_t sh_q;
   lls_word_t word_q;
   lls_word_t next_sh;

   assign next_sh = {sh_q[6:0], bit_i};

   ////////////////////////////////////////////////////////////////////////
   // Bit collection at bit rate
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sh_q <= LLS_WORD_RST;
      else
         sh_q <= next_sh;
   end

   // Word handed over only on the strobe, upper bits masked off
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         word_q <= LLS_WORD_RST;
      else if (word_stb_i)
         word_q <= next_sh & lls_width_mask(width_i);
   end

   assign word_o = word_q;

   // Judged against the width in force at the strobe; a narrower width set
   // later may legally leave an older, wider word in place until the next one
   word_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      word_stb_i |=> (word_q & ~lls_width_mask($past(width_i))) == LLS_WORD_RST)
      else $error("rx word has bits above width");

endmodule

// ==== design/lls_lane_top.sv ====
// LVDS lane: serializer, deserializer, bypass buffers, clock forwarding.
// Assumes clk_sys_i is the serial bit clock; core logic on the same clock
// uses the word strobe outputs as its word-rate enable. Pad inputs are
// asynchronous and are synchronised here.
`timescale 1ns/100ps
module lls_lane_top
   import lls_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Transmit side
   input  wire lls_tx_cfg_s tx_cfg_i,
   input  wire lls_word_t   tx_data_i,
   input  wire logic        tx_oe_i,
   output logic            tx_word_stb_o,
   output logic            tx_pad_pos_o,
   output logic            tx_pad_neg_o,
   output logic            tx_pad_oe_o,
   // Receive side
   input  wire lls_rx_cfg_s rx_cfg_i,
   input  wire logic        rx_pad_pos_i,
   input  wire logic        rx_pad_neg_i,
   output logic            rx_word_stb_o,
   output lls_word_t       rx_data_o,
   output logic            rx_alternate_out_o,
   output logic [10:0]     rx_delay_ps_o
);

   ////////////////////////////////////////////////////////////////////////
   // Transmit word-rate divider

   logic [3:0] tx_w_d;
   logic [3:0] tx_w_q;
   logic [3:0] tx_cnt_q;
   logic       tx_stb;
   logic       tx_ser_data;
   logic       tx_ref_clk;
   logic       tx_bypass;

   // Each side has its own width and divider, so lanes never interact
   assign tx_w_d      = lls_eff_width(tx_cfg_i.ser_en, tx_cfg_i.width);
   assign tx_bypass   = (tx_w_q == LLS_W_BYPASS);
   assign tx_ref_clk  = tx_cfg_i.ref_clk_mode && !tx_bypass;
   assign tx_ser_data = !tx_cfg_i.ref_clk_mode && !tx_bypass;
   assign tx_stb      = (tx_cnt_q == 4'(tx_w_q - 4'h1));

   // Width registered so the divider never sees a mid-word glitch
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         tx_w_q <= LLS_W_BYPASS;
      else
         tx_w_q <= tx_w_d;
   end

   // Word strobe every tx_w_q bit periods
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || tx_stb || tx_w_d != tx_w_q)
         tx_cnt_q <= LLS_CNT_RST;
      else
         tx_cnt_q <= 4'(tx_cnt_q + 4'h1);
   end

   assign tx_word_stb_o = tx_stb;

   ////////////////////////////////////////////////////////////////////////
   // Transmit shifter and forwarded clock

   logic       tx_ser_bit;
   logic       tx_tog_q;
   logic [3:0] tx_half;
   logic       tx_clk_bit;

   lls_tx_ser u_tx_ser (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .word_stb_i (tx_stb),
      .width_i    (tx_w_q),
      .word_i     (tx_data_i),
      .ser_bit_o  (tx_ser_bit)
   );

   // Per-word toggle for the divided forwarded clock
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !tx_ref_clk)
         tx_tog_q <= LLS_PAD_RST;
      else if (tx_stb)
         tx_tog_q <= !tx_tog_q;
   end

   // Odd widths give a high phase one bit longer than the low phase
   assign tx_half    = 4'((tx_w_q + 4'h1) >> 1);
   assign tx_clk_bit = tx_cfg_i.clk_div2 ? tx_tog_q : (tx_cnt_q < tx_half);

   ////////////////////////////////////////////////////////////////////////
   // Transmit pad drivers

   logic tx_pos_q;
   logic tx_neg_q;
   logic tx_oe_q;

   // Pad pair always complementary; source picked by mode
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         tx_pos_q <= LLS_PAD_RST;
         tx_neg_q <= !LLS_PAD_RST;
      end
      else if (tx_ref_clk)
      begin
         tx_pos_q <= tx_clk_bit;
         tx_neg_q <= !tx_clk_bit;
      end
      else if (tx_ser_data)
      begin
         tx_pos_q <= tx_ser_bit;
         tx_neg_q <= !tx_ser_bit;
      end
      else
      begin
         tx_pos_q <= tx_data_i[0];
         tx_neg_q <= !tx_data_i[0];
      end
   end

   // Enable input only honoured as a plain buffer; serial modes always drive
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         tx_oe_q <= 1'b0;
      else
         tx_oe_q <= tx_bypass ? tx_oe_i : 1'b1;
   end

   assign tx_pad_pos_o = tx_pos_q;
   assign tx_pad_neg_o = tx_neg_q;
   assign tx_pad_oe_o  = tx_oe_q;

   ////////////////////////////////////////////////////////////////////////
   // Receive pad synchroniser and differential decision

   logic rx_pos_m_q;
   logic rx_pos_s_q;
   logic rx_neg_m_q;
   logic rx_neg_s_q;
   logic rx_bit_q;

   // Two stages; only the second stage feeds logic
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rx_pos_m_q <= LLS_PAD_RST;
         rx_pos_s_q <= LLS_PAD_RST;
         rx_neg_m_q <= LLS_PAD_RST;
         rx_neg_s_q <= LLS_PAD_RST;
      end
      else
      begin
         rx_pos_m_q <= rx_pad_pos_i;
         rx_pos_s_q <= rx_pos_m_q;
         rx_neg_m_q <= rx_pad_neg_i;
         rx_neg_s_q <= rx_neg_m_q;
      end
   end

   // Equal legs mean no valid differential level: hold the last bit
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         rx_bit_q <= LLS_PAD_RST;
      else if (rx_pos_s_q != rx_neg_s_q)
         rx_bit_q <= rx_pos_s_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive word-rate divider

   logic [3:0] rx_w_d;
   logic [3:0] rx_w_q;
   logic [3:0] rx_cnt_q;
   logic       rx_stb;
   logic       rx_bypass;
   logic       rx_alt_act;

   assign rx_w_d     = lls_eff_width(rx_cfg_i.ser_en, rx_cfg_i.width);
   assign rx_bypass  = (rx_w_q == LLS_W_BYPASS);
   assign rx_alt_act = rx_bypass && rx_cfg_i.alt_conn;
   assign rx_stb     = (rx_cnt_q == 4'(rx_w_q - 4'h1));

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         rx_w_q <= LLS_W_BYPASS;
      else
         rx_w_q <= rx_w_d;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || rx_stb || rx_w_d != rx_w_q)
         rx_cnt_q <= LLS_CNT_RST;
      else
         rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
   end

   assign rx_word_stb_o = rx_stb;

   ////////////////////////////////////////////////////////////////////////
   // Receive deserializer and outputs

   lls_word_t rx_des_word;
   lls_word_t rx_data_q;
   logic      rx_alt_q;
   logic [10:0] rx_dly_q;

   lls_rx_des u_rx_des (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .word_stb_i (rx_stb),
      .width_i    (rx_w_q),
      .bit_i      (rx_bit_q),
      .word_o     (rx_des_word)
   );

   // Width one strobes every bit, so bypass passes the pad level through; with the alternate connection the word is held at zero
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || rx_alt_act)
         rx_data_q <= LLS_WORD_RST;
      else
         rx_data_q <= rx_des_word;
   end

   // Alternate path feeds a PLL reference; dead in every other mode
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !rx_alt_act)
         rx_alt_q <= LLS_PAD_RST;
      else
         rx_alt_q <= rx_bit_q;
   end

   // Sub-cycle delay cannot be realised at this clock; reported in ps only
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         rx_dly_q <= 11'h000;
      else
         rx_dly_q <= 11'(rx_cfg_i.delay * LLS_DLY_STEP_PS);
   end

   assign rx_data_o          = rx_data_q;
   assign rx_alternate_out_o = rx_alt_q;
   assign rx_delay_ps_o      = rx_dly_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   logic       tx_first_bit;
   logic [3:0] tx_gap_q;
   logic       tx_gap_ok_q;

   assign tx_first_bit = tx_data_i[3'(tx_w_q - 4'h1)];

   // Gap since the last strobe, forgotten when the width changes
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || tx_w_d != tx_w_q)
      begin
         tx_gap_q    <= LLS_CNT_RST;
         tx_gap_ok_q <= 1'b0;
      end
      else if (tx_stb)
      begin
         tx_gap_q    <= LLS_CNT_RST;
         tx_gap_ok_q <= 1'b1;
      end
      else
         tx_gap_q <= 4'(tx_gap_q + 4'h1);
   end

   sequence tx_word_start;
      tx_ser_data && tx_stb && tx_w_d == tx_w_q;
   endsequence

   sequence tx_ref_start;
      tx_ref_clk && tx_stb && $stable(tx_cfg_i);
   endsequence

   tx_first_bit_a: assert property (tx_word_start ##0 tx_ser_data [*3] |->
      tx_pad_pos_o == $past(tx_first_bit, 2))
      else $error("tx first bit not on pad two cycles after strobe");

   word_period_a: assert property (tx_stb && tx_gap_ok_q |->
      tx_gap_q == 4'(tx_w_q - 4'h1))
      else $error("tx word strobe spacing wrong");

   width_range_a: assert property (tx_w_q >= LLS_W_BYPASS && tx_w_q <= LLS_W_MAX &&
      rx_w_q >= LLS_W_BYPASS && rx_w_q <= LLS_W_MAX)
      else $error("working width out of range");

   clk_div1_a: assert property (tx_ref_start ##0 !tx_cfg_i.clk_div2 ##1
      $stable(tx_cfg_i) [*2] |-> tx_pad_pos_o)
      else $error("word-rate clock not high at word start");

   clk_div2_a: assert property (tx_ref_start ##0 tx_cfg_i.clk_div2 ##1
      $stable(tx_cfg_i) [*2] |-> tx_pad_pos_o != $past(tx_pad_pos_o))
      else $error("half-rate clock did not toggle");

   pad_pair_a: assert property (tx_pad_pos_o != tx_pad_neg_o)
      else $error("tx pads not complementary");

   oe_serial_a: assert property (!tx_bypass |=> tx_pad_oe_o)
      else $error("serial mode lost output enable");

   rx_pass_a: assert property ((rx_bypass && !rx_alt_act && rx_w_d == rx_w_q) [*3] |->
      rx_data_o == {7'h00, $past(rx_bit_q, 2)})
      else $error("bypass receive level not passed");

   rx_hold_a: assert property (!rx_bypass && !$past(rx_stb) && !$past(rx_stb, 2) &&
      !rx_alt_act |-> $stable(rx_data_o))
      else $error("rx word changed off strobe");

   alt_gate_a: assert property (!rx_alt_act [*2] |-> !rx_alternate_out_o)
      else $error("alternate output active outside bypass");

   dly_scale_a: assert property (##1 rx_delay_ps_o ==
      11'($past(rx_cfg_i.delay) * LLS_DLY_STEP_PS))
      else $error("delay report not 25 ps per step");

endmodule

// ==== verif/lls_lvds_peer.sv ====
// Far-end LVDS peer: drives the receive pair and watches the transmit pair.
// Assumes the bench changes drive_i and bit_i just after rising edges.
`timescale 1ns/100ps
module lls_lvds_peer
(
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic drive_i,
   input  wire logic bit_i,
   input  wire logic tx_pad_pos_i,
   input  wire logic tx_pad_neg_i,
   output logic      rx_pad_pos_o,
   output logic      rx_pad_neg_o,
   output logic      leg_fault_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Released pair floats to the weak pull-up, so both legs read high
   assign rx_pad_pos_o = drive_i ? bit_i : 1'b1;
   assign rx_pad_neg_o = drive_i ? ~bit_i : 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky flag for equal transmit legs; an unknown leg is not flagged here
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         leg_fault_o <= 1'b0;
      else if ((tx_pad_pos_i ^ tx_pad_neg_i) === 1'b0)
         leg_fault_o <= 1'b1;
   end
endmodule

// ==== verif/lls_lane_top_tb.sv ====
// Self-checking bench for the LVDS lane: serial, clock, bypass and receive paths.
// Assumes a 100 MHz bit clock and the far-end peer model on the pads.
`timescale 1ns/100ps
module lls_lane_top_tb
   import lls_pkg::*;
;
   logic        clk_sys_i;
   logic        rst_i;
   lls_tx_cfg_s tx_cfg;
   lls_rx_cfg_s rx_cfg;
   lls_word_t   tx_data;
   lls_word_t   rx_data;
   logic        tx_oe, tx_stb, tx_pos, tx_neg, tx_pad_oe;
   logic        rx_pos, rx_neg, rx_stb, rx_alt, drv, sbit, leg_fault;
   logic [10:0] dly_ps;
   int          failures;
   int          cmp_count;

   lls_lane_top lls_lane_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_cfg_i(tx_cfg),
      .tx_data_i(tx_data), .tx_oe_i(tx_oe), .tx_word_stb_o(tx_stb), .tx_pad_pos_o(tx_pos),
      .tx_pad_neg_o(tx_neg), .tx_pad_oe_o(tx_pad_oe), .rx_cfg_i(rx_cfg),
      .rx_pad_pos_i(rx_pos), .rx_pad_neg_i(rx_neg), .rx_word_stb_o(rx_stb),
      .rx_data_o(rx_data), .rx_alternate_out_o(rx_alt), .rx_delay_ps_o(dly_ps));

   lls_lvds_peer lls_lvds_peer_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .drive_i(drv),
      .bit_i(sbit), .tx_pad_pos_i(tx_pos), .tx_pad_neg_i(tx_neg), .rx_pad_pos_o(rx_pos),
      .rx_pad_neg_o(rx_neg), .leg_fault_o(leg_fault));

   ////////////////////////////////////////////////////////////////////////////////
   // Expectation helpers
   function automatic logic [15:0] mask_of(input int w);
      return 16'((1 << w) - 1);
   endfunction

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Serial transmit: words taken on strobe, bits expected two edges later
   task automatic tx_run(input int w);
      logic q[$];
      int   n;
      bit   on;
      n = 0;
      on = 0;
      tx_cfg <= '{1'b0, 1'b1, 4'(w), 1'b0};
      tick(4);
      repeat (6 * w + 4)
      begin
         @(posedge clk_sys_i);
         if (on)
            n++;
         if (n >= 2 && q.size() > 0)
         begin
            chk("tx_bit", 16'(tx_pos), 16'(q.pop_front()));
            chk("tx_oe", 16'(tx_pad_oe), 16'h1);
         end
         if (tx_stb === 1'b1)
         begin
            // MSB leaves first, so queue from bit w-1 down
            for (int i = w - 1; i >= 0; i--)
               q.push_back(tx_data[i]);
            on = 1;
            tx_data <= lls_word_t'($urandom);
         end
      end
      chk("tx_words", 16'(on), 16'h1);
   endtask

   // Forwarded clock: transitions over 16 intervals fix the output rate
   task automatic ref_run(input logic div2);
      int   tog;
      logic last;
      tx_cfg <= '{1'b1, 1'b1, 4'h4, div2};
      tick(10);
      last = tx_pos;
      tog = 0;
      repeat (16)
      begin
         @(posedge clk_sys_i);
         tog += int'(tx_pos != last);
         last = tx_pos;
      end
      chk("ref_toggles", 16'(tog), div2 ? 16'h4 : 16'h8);
   endtask

   // Receive: one set bit per word period, so each word holds exactly one
   task automatic rx_run(input int w);
      int last;
      last = 0;
      rx_cfg <= '{1'b1, 4'(w), 1'b0, 6'h00};
      drv <= 1'b1;
      for (int k = 0; k < 8 * w + 16; k++)
      begin
         @(posedge clk_sys_i);
         sbit <= (k % w == 0);
         // Word strobe must repeat every w bit periods once settled
         if (rx_stb === 1'b1)
         begin
            if (k > 6 * w + 8)
               chk("rx_stb_gap", 16'(k - last), 16'(w));
            last = k;
         end
         if (k > 6 * w + 8)
         begin
            chk("rx_ones", 16'($countones(rx_data)), 16'h1);
            chk("rx_high", 16'(rx_data) & ~mask_of(w), 16'h0);
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Main sequence
   initial
   begin
      logic       pd, po, s, a, v;
      logic [5:0] d;
      failures = 0;
      cmp_count = 0;
      rst_i = 1'b1;
      tx_cfg = '{1'b0, 1'b1, 4'h8, 1'b0};
      rx_cfg = '{1'b1, 4'h8, 1'b0, 6'h00};
      tx_data = 8'h00;
      tx_oe = 1'b0;
      drv = 1'b0;
      sbit = 1'b0;
      void'($urandom(32'h55b57e05));
      tick(8);
      rst_i <= 1'b0;
      for (int w = 2; w <= 8; w++)
         tx_run(w);
      ref_run(1'b0);
      ref_run(1'b1);
      // Serializer off: pad and enable follow the inputs one edge later
      tx_cfg <= '{1'b0, 1'b0, 4'h8, 1'b0};
      tick(3);
      pd = tx_data[0];
      po = tx_oe;
      repeat (24)
      begin
         @(posedge clk_sys_i);
         chk("byp_pad", 16'(tx_pos), 16'(pd));
         chk("byp_oe", 16'(tx_pad_oe), 16'(po));
         pd = tx_data[0];
         po = tx_oe;
         tx_data <= lls_word_t'($urandom);
         tx_oe <= 1'($urandom);
      end
      for (int w = 2; w <= 8; w++)
         rx_run(w);
      // Bypass, alternate and static delay table, delay corners 0 and 63
      for (int m = 0; m < 6; m++)
      begin
         s = (m >= 4);
         a = (m >= 2);
         v = m[0];
         d = (m == 0) ? 6'h00 : (m == 5) ? 6'h3f : 6'($urandom);
         rx_cfg <= '{s, 4'h4, a, d};
         sbit <= v;
         tick(20);
         chk("rx_word", 16'(rx_data), s ? (v ? mask_of(4) : 16'h0) : 16'(v & !a));
         chk("rx_alt", 16'(rx_alt), 16'(v & a & !s));
         chk("rx_dly", 16'(dly_ps), 16'(d) * 16'h19);
      end
      // Released pair floats high on both legs: last received level is kept
      drv <= 1'b0;
      tick(20);
      chk("rx_hold", 16'(rx_data), mask_of(4));
      chk("leg_fault", 16'(leg_fault), 16'h0);
      conclude();
   end
endmodule
